// ==== design/bq_pkg.sv ====
`default_nettype none
package bq_pkg;
	// Register byte offsets
	localparam logic [7:0] BQ_OFS_EVENT_SEL = 8'h00;
	localparam logic [7:0] BQ_OFS_COUNTER_CFG = 8'h04;
	localparam logic [7:0] BQ_OFS_TALLY = 8'h08;
	localparam logic [7:0] BQ_OFS_STATUS = 8'h0c;
	// Reset values
	localparam logic [31:0] BQ_RST_EVENT_SEL = 32'h0000_0000;
	localparam logic [31:0] BQ_RST_COUNTER_CFG = 32'h0000_0000;
	localparam logic [15:0] BQ_RST_TALLY = 16'h0000;
	// Event selection register fields
	localparam int BQ_SEL_HI = 31;
	localparam int BQ_SEL_LO = 25;
	localparam int BQ_MASK_HI = 24;
	localparam int BQ_MASK_LO = 9;
	// Counter configuration select field
	localparam int BQ_CSEL_HI = 15;
	localparam int BQ_CSEL_LO = 13;
	localparam logic [2:0] BQ_CSEL_QUEUE_ALLOC = 3'h6;
	// Event select codes
	localparam logic [6:0] BQ_EVT_QUEUE_ALLOC = 7'h03;
	localparam logic [6:0] BQ_EVT_BUS_DATA = 7'h17;
	// Queue allocation mask layout
	localparam int BQ_QM_TYPE_HI = 4;
	localparam int BQ_QM_TYPE_LO = 0;
	localparam logic [4:0] BQ_QM_TYPE_DEFAULT = 5'h01;
	localparam int BQ_QM_ALL_READ = 5;
	localparam int BQ_QM_ALL_WRITE = 6;
	localparam int BQ_QM_UC = 7;
	localparam int BQ_QM_WC = 8;
	localparam int BQ_QM_OWN = 13;
	localparam int BQ_QM_OTHER = 14;
	localparam int BQ_QM_PREFETCH = 15;
	// Bus data activity mask layout
	localparam int BQ_DM_RDY_DRV = 0;
	localparam int BQ_DM_RDY_OWN = 1;
	localparam int BQ_DM_RDY_OTHER = 2;
	localparam int BQ_DM_BSY_DRV = 3;
	localparam int BQ_DM_BSY_OWN = 4;
	localparam int BQ_DM_BSY_OTHER = 5;

	function automatic logic [15:0] bq_mask(input logic [31:0] esel);
		bq_mask = esel[BQ_MASK_HI:BQ_MASK_LO];
	endfunction : bq_mask

	function automatic logic [6:0] bq_select(input logic [31:0] esel);
		bq_select = esel[BQ_SEL_HI:BQ_SEL_LO];
	endfunction : bq_select
endpackage : bq_pkg
`default_nettype wire

// ==== design/bq_alloc_qual.sv ====
`timescale 1ns/100ps
`default_nettype none
module bq_alloc_qual
	import bq_pkg::*;
(
	// Mask
	input wire logic [15:0] mask,
	// Queue allocation attributes
	input wire logic alloc_valid,
	input wire logic [4:0] alloc_req_type,
	input wire logic alloc_is_read,
	input wire logic alloc_uncacheable,
	input wire logic alloc_write_combining,
	input wire logic alloc_self_driven,
	input wire logic alloc_is_store,
	input wire logic alloc_prefetch,
	// Result
	output logic hit
);
	logic type_ok;
	logic rw_ok;
	logic mem_ok;
	logic origin_ok;
	logic prefetch_ok;

	always_comb begin
		// Encoded type field; default code accepts any type
		type_ok = (mask[BQ_QM_TYPE_HI:BQ_QM_TYPE_LO] == BQ_QM_TYPE_DEFAULT) ||
			(mask[BQ_QM_TYPE_HI:BQ_QM_TYPE_LO] == alloc_req_type); // [RULE1] [RULE2]
		rw_ok = (mask[BQ_QM_ALL_READ] && alloc_is_read) ||
			(mask[BQ_QM_ALL_WRITE] && !alloc_is_read); // [RULE3]
		mem_ok = !(mask[BQ_QM_UC] || mask[BQ_QM_WC]) ||
			(mask[BQ_QM_UC] && alloc_uncacheable) ||
			(mask[BQ_QM_WC] && alloc_write_combining); // [RULE3]
		origin_ok = (mask[BQ_QM_OWN] && alloc_self_driven && alloc_is_store) || // [RULE4]
			(mask[BQ_QM_OTHER] && !alloc_self_driven); // [RULE5]
		prefetch_ok = mask[BQ_QM_PREFETCH] || !alloc_prefetch; // [RULE6]
		// Every allocation, retries included, is judged afresh
		hit = alloc_valid && type_ok && rw_ok && mem_ok && origin_ok && prefetch_ok; // [RULE12]
	end
endmodule : bq_alloc_qual
`default_nettype wire

// ==== design/bq_data_qual.sv ====
`timescale 1ns/100ps
`default_nettype none
module bq_data_qual
	import bq_pkg::*;
(
	// Mask
	input wire logic [15:0] mask,
	// Bus data phase
	input wire logic data_ready_signal,
	input wire logic data_busy_signal,
	input wire logic bus_self_driving,
	input wire logic bus_self_owner,
	// Result
	output logic hit
);
	logic ready_self_driven;
	logic ready_self_owned;
	logic ready_foreign_driven;
	logic busy_self_driven;
	logic busy_self_owned;
	logic busy_foreign_driven;

	always_comb begin
		ready_self_driven = data_ready_signal && bus_self_driving;
		ready_self_owned = data_ready_signal && bus_self_owner;
		ready_foreign_driven = data_ready_signal && !bus_self_driving;
		busy_self_driven = data_busy_signal && bus_self_driving;
		busy_self_owned = data_busy_signal && bus_self_owner;
		busy_foreign_driven = data_busy_signal && !bus_self_driving;
		hit = (mask[BQ_DM_RDY_DRV] && ready_self_driven) || // [RULE10]
			(mask[BQ_DM_RDY_OWN] && ready_self_owned) || // [RULE10]
			(mask[BQ_DM_RDY_OTHER] && ready_foreign_driven) || // [RULE10]
			(mask[BQ_DM_BSY_DRV] && busy_self_driven) || // [RULE11]
			(mask[BQ_DM_BSY_OWN] && busy_self_owned) || // [RULE11]
			(mask[BQ_DM_BSY_OTHER] && busy_foreign_driven); // [RULE11]
	end
endmodule : bq_data_qual
`default_nettype wire

// ==== design/bq_event_qualifier.sv ====
// Summary of operation
// [RULE1] Mask is bits 24:9, low five encoded
// [RULE2] Select 03H counts matching request types
// [RULE3] Mask bits pick read/write, UC/WC entries
// [RULE4] Bit 13 counts own driven store requests
// [RULE5] Bit 14 counts other processor/DMA requests
// [RULE6] Bit 15 clear excludes prefetch reads
// [RULE7] Software sets config select 06H, edge
// [RULE8] Privilege filter ignored for queue allocations
// [RULE9] Select 17H counts selected data activity
// [RULE10] Bits 0-2 select data-ready cases
// [RULE11] Bits 3-5 select data-busy cases
// [RULE12] Each queue entry, every retry, counts
// [RULE13] One increment pulse per qualifying cycle
`timescale 1ns/100ps
`default_nettype none
module bq_event_qualifier
	import bq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Queue allocation
	input wire logic alloc_valid,
	input wire logic [4:0] alloc_req_type,
	input wire logic alloc_is_read,
	input wire logic alloc_uncacheable,
	input wire logic alloc_write_combining,
	input wire logic alloc_self_driven,
	input wire logic alloc_is_store,
	input wire logic alloc_prefetch,
	// Bus data phase
	input wire logic data_ready_signal,
	input wire logic data_busy_signal,
	input wire logic bus_self_driving,
	input wire logic bus_self_owner,
	// Count increments
	output logic count_inc,
	output logic alloc_inc,
	output logic data_inc
);
	typedef struct packed {
		logic [31:0] event_selection_reg;
		logic [31:0] counter_config_reg;
		logic [15:0] alloc_tally;
		logic [15:0] data_tally;
		logic count_inc;
		logic alloc_inc;
		logic data_inc;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} bq_state_s;

	bq_state_s state_reg;
	bq_state_s state_next;
	logic [15:0] mask;
	logic [6:0] select;
	logic alloc_hit;
	logic data_hit;
	logic setup;
	logic access;
	logic mapped;
	logic count_hit;

	function automatic logic [31:0] bq_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		bq_merge = r;
	endfunction : bq_merge

	// Privilege filter bits 8:0 are stored but never consulted
	assign mask = bq_mask(state_reg.event_selection_reg); // [RULE1] [RULE8]
	assign select = bq_select(state_reg.event_selection_reg);

	bq_alloc_qual u_alloc (
		.mask(mask),
		.alloc_valid(alloc_valid),
		.alloc_req_type(alloc_req_type),
		.alloc_is_read(alloc_is_read),
		.alloc_uncacheable(alloc_uncacheable),
		.alloc_write_combining(alloc_write_combining),
		.alloc_self_driven(alloc_self_driven),
		.alloc_is_store(alloc_is_store),
		.alloc_prefetch(alloc_prefetch),
		.hit(alloc_hit)
	);

	bq_data_qual u_data (
		.mask(mask),
		.data_ready_signal(data_ready_signal),
		.data_busy_signal(data_busy_signal),
		.bus_self_driving(bus_self_driving),
		.bus_self_owner(bus_self_owner),
		.hit(data_hit)
	);

	always_comb begin
		setup = psel && !penable;
		access = psel && penable && state_reg.pready;
		mapped = (paddr == BQ_OFS_EVENT_SEL) || (paddr == BQ_OFS_COUNTER_CFG) ||
			(paddr == BQ_OFS_TALLY) || (paddr == BQ_OFS_STATUS);
		count_hit = ((select == BQ_EVT_QUEUE_ALLOC) && alloc_hit) || // [RULE2]
			((select == BQ_EVT_BUS_DATA) && data_hit); // [RULE9]
		state_next = state_reg;
		// Selected event pulse, one per cycle at most
		state_next.count_inc = count_hit; // [RULE13]
		state_next.alloc_inc = alloc_hit; // [RULE12]
		state_next.data_inc = data_hit; // [RULE9]
		if (alloc_hit) begin
			state_next.alloc_tally = state_reg.alloc_tally + 16'h0001;
		end
		if (data_hit) begin
			state_next.data_tally = state_reg.data_tally + 16'h0001;
		end
		// APB: one access cycle, answer registered in setup
		state_next.pready = setup;
		state_next.pslverr = setup && !mapped;
		state_next.prdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			unique case (paddr)
				BQ_OFS_EVENT_SEL: state_next.prdata = state_reg.event_selection_reg;
				BQ_OFS_COUNTER_CFG: state_next.prdata = state_reg.counter_config_reg;
				BQ_OFS_TALLY: state_next.prdata = {state_reg.data_tally, state_reg.alloc_tally};
				BQ_OFS_STATUS: state_next.prdata = {29'h0000_0000, state_reg.data_inc,
					state_reg.alloc_inc, state_reg.count_inc};
				default: state_next.prdata = 32'h0000_0000;
			endcase
		end
		if (access && pwrite) begin
			unique case (paddr)
				BQ_OFS_EVENT_SEL: state_next.event_selection_reg =
					bq_merge(state_reg.event_selection_reg, pwdata, pstrb);
				BQ_OFS_COUNTER_CFG: state_next.counter_config_reg =
					bq_merge(state_reg.counter_config_reg, pwdata, pstrb);
				BQ_OFS_TALLY: begin
					state_next.alloc_tally = alloc_hit ? 16'h0001 : BQ_RST_TALLY;
					state_next.data_tally = data_hit ? 16'h0001 : BQ_RST_TALLY;
				end
				default: state_next.prdata = 32'h0000_0000;
			endcase
		end
		if (!access) begin
			state_next.pready = setup;
		end else begin
			state_next.pready = 1'b0;
			state_next.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.event_selection_reg <= BQ_RST_EVENT_SEL;
			state_reg.counter_config_reg <= BQ_RST_COUNTER_CFG;
			state_reg.alloc_tally <= BQ_RST_TALLY;
			state_reg.data_tally <= BQ_RST_TALLY;
			state_reg.count_inc <= 1'b0;
			state_reg.alloc_inc <= 1'b0;
			state_reg.data_inc <= 1'b0;
			state_reg.pready <= 1'b0;
			state_reg.pslverr <= 1'b0;
			state_reg.prdata <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign count_inc = state_reg.count_inc;
	assign alloc_inc = state_reg.alloc_inc;
	assign data_inc = state_reg.data_inc;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_TYPE_FIELD: assert property (alloc_valid && // [RULE1]
		mask[4:0] != BQ_QM_TYPE_DEFAULT && mask[4:0] != alloc_req_type |=> !alloc_inc)
		else $error("request type field mismatch still counted");
	AST_ALLOC_SEL: assert property ((select == BQ_EVT_QUEUE_ALLOC) && alloc_hit // [RULE2]
		|=> count_inc)
		else $error("queue allocation not counted under its select");
	AST_RW_SEL: assert property (alloc_valid && alloc_is_read && !mask[BQ_QM_ALL_READ] // [RULE3]
		|=> !alloc_inc)
		else $error("read entry counted without read select");
	AST_MEM_SEL: assert property (alloc_valid && mask[BQ_QM_UC] && !mask[BQ_QM_WC] && // [RULE3]
		!alloc_uncacheable |=> !alloc_inc)
		else $error("non-uncacheable entry counted under uncacheable select");
	AST_OWN_STORE: assert property (alloc_valid && alloc_self_driven && // [RULE4]
		!(mask[BQ_QM_OWN] && alloc_is_store) |=> !alloc_inc)
		else $error("own request counted without own store select");
	AST_OTHER: assert property (alloc_valid && !alloc_self_driven && // [RULE5]
		!mask[BQ_QM_OTHER] |=> !alloc_inc)
		else $error("foreign request counted without other select");
	AST_PREFETCH: assert property (alloc_valid && alloc_prefetch && // [RULE6]
		!mask[BQ_QM_PREFETCH] |=> !alloc_inc)
		else $error("prefetch counted while excluded");
	AST_DATA_SEL: assert property ((select == BQ_EVT_BUS_DATA) && data_hit // [RULE9]
		|=> count_inc && data_inc)
		else $error("bus data activity not counted under its select");
	AST_READY_DRV: assert property (data_ready_signal && bus_self_driving && // [RULE10]
		mask[BQ_DM_RDY_DRV] |=> data_inc)
		else $error("self driven data ready missed");
	AST_BUSY_OTHER: assert property (data_busy_signal && !bus_self_driving && // [RULE11]
		mask[BQ_DM_BSY_OTHER] |=> data_inc)
		else $error("foreign driven data busy missed");
	AST_RETRY: assert property (alloc_hit [*2] |-> alloc_inc [*2]) // [RULE12]
		else $error("repeated allocation not counted twice");
	AST_PULSE_CAUSE: assert property (count_inc |-> // [RULE13]
		$past(select) == BQ_EVT_QUEUE_ALLOC || $past(select) == BQ_EVT_BUS_DATA)
		else $error("increment without a counting select");
	AST_APB_ONE: assert property (pready |=> !pready)
		else $error("ready held beyond one cycle");

	COV_ALLOC: cover property ((select == BQ_EVT_QUEUE_ALLOC) ##1 count_inc [*2]);
	COV_DATA: cover property ((select == BQ_EVT_BUS_DATA) ##1 count_inc);
	COV_WRITE: cover property (psel && penable && pready && pwrite && !pslverr);
	COV_ERR: cover property (pready && pslverr);
endmodule : bq_event_qualifier
`default_nettype wire

// ==== verif/bq_bus_agent.sv ====
`timescale 1ns/100ps
`default_nettype none
module bq_bus_agent (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench stimulus
	input wire logic [11:0] aw,
	input wire logic [3:0] dw,
	// Queue allocation
	output logic alloc_valid,
	output logic [4:0] alloc_req_type,
	output logic alloc_is_read,
	output logic alloc_uncacheable,
	output logic alloc_write_combining,
	output logic alloc_self_driven,
	output logic alloc_is_store,
	output logic alloc_prefetch,
	// Bus data phase
	output logic data_ready_signal,
	output logic data_busy_signal,
	output logic bus_self_driving,
	output logic bus_self_owner
);
	logic [10:0] last_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reg <= 11'h000;
		end else if (aw[11]) begin
			last_reg <= aw[10:0];
		end
	end
	// Idle cycles show the last attributes inverted
	assign {alloc_valid, alloc_req_type, alloc_is_read, alloc_uncacheable, alloc_write_combining,
		alloc_self_driven, alloc_is_store, alloc_prefetch} = aw[11] ? aw : {1'b0, ~last_reg};
	assign {data_ready_signal, data_busy_signal, bus_self_driving, bus_self_owner} = dw;
endmodule : bq_bus_agent
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import bq_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, count_inc, alloc_inc, data_inc;
	logic alloc_valid, alloc_is_read, alloc_uncacheable, alloc_write_combining;
	logic alloc_self_driven, alloc_is_store, alloc_prefetch;
	logic [4:0] alloc_req_type;
	logic data_ready_signal, data_busy_signal, bus_self_driving, bus_self_owner;
	logic [11:0] aw = 12'h000;
	logic [3:0] dw = 4'h0;
	int err_total = 0;
	int check_count = 0;

	always #2.5 pclk = ~pclk;

	bq_bus_agent agent (.pclk, .presetn, .aw, .dw, .alloc_valid, .alloc_req_type, .alloc_is_read,
		.alloc_uncacheable, .alloc_write_combining, .alloc_self_driven, .alloc_is_store,
		.alloc_prefetch, .data_ready_signal, .data_busy_signal, .bus_self_driving, .bus_self_owner);

	bq_event_qualifier DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .alloc_valid, .alloc_req_type, .alloc_is_read,
		.alloc_uncacheable, .alloc_write_combining, .alloc_self_driven, .alloc_is_store,
		.alloc_prefetch, .data_ready_signal, .data_busy_signal, .bus_self_driving,
		.bus_self_owner, .count_inc, .alloc_inc, .data_inc);

	task close_out;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	task chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
		end
	endtask : chk_word

	task chk_bit(input logic g, input logic x, input string m);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("wrong value at %0t: %s got %b want %b", $time, m, g, x);
		end
	endtask : chk_bit

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task t_regs;
		apb(1'b0, BQ_OFS_EVENT_SEL, 32'h0);
		chk_word(rd, BQ_RST_EVENT_SEL, "event select reset");
		apb(1'b1, BQ_OFS_COUNTER_CFG, {16'h0, BQ_CSEL_QUEUE_ALLOC, 13'h0});
		apb(1'b0, BQ_OFS_COUNTER_CFG, 32'h0);
		chk_word(rd, {16'h0, BQ_CSEL_QUEUE_ALLOC, 13'h0}, "config readback");
		apb(1'b0, 8'h10, 32'h0);
		chk_bit(er, 1'b1, "unmapped error");
	endtask : t_regs

	task qa(input logic [15:0] m, input logic [11:0] a, input logic x);
		apb(1'b1, BQ_OFS_EVENT_SEL, {BQ_EVT_QUEUE_ALLOC, m, 9'h000});
		@(posedge pclk);
		aw <= a;
		@(posedge pclk);
		aw <= 12'h000;
		@(negedge pclk);
		chk_bit(count_inc, x, "count pulse");
		chk_bit(alloc_inc, x, "alloc pulse");
	endtask : qa

	task t_alloc;
		qa(16'he061, 12'h8a0, 1'b1);
		qa(16'he065, 12'h8a0, 1'b0);
		qa(16'he065, 12'h960, 1'b1);
		qa(16'he041, 12'h8a0, 1'b0);
		qa(16'he0e1, 12'h8a8, 1'b0);
		qa(16'he161, 12'h8a8, 1'b1);
		qa(16'h2061, 12'h886, 1'b1);
		qa(16'h2061, 12'h884, 1'b0);
		qa(16'h4061, 12'h8a0, 1'b1);
		qa(16'h4061, 12'h886, 1'b0);
		qa(16'h6061, 12'h8a1, 1'b0);
		qa(16'he061, 12'h8a1, 1'b1);
	endtask : t_alloc

	task t_burst;
		// Privilege filter bits set: queue allocations must still count
		apb(1'b1, BQ_OFS_EVENT_SEL, {BQ_EVT_QUEUE_ALLOC, 16'he061, 9'h1ff});
		apb(1'b1, BQ_OFS_TALLY, 32'h0);
		@(posedge pclk);
		aw <= 12'h8a0;
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			if (i == 2) begin
				aw <= 12'h000;
			end
			@(negedge pclk);
			chk_bit(count_inc, 1'b1, "retry pulse");
		end
		@(negedge pclk);
		chk_bit(count_inc, 1'b0, "pulse ends");
		apb(1'b0, BQ_OFS_TALLY, 32'h0);
		chk_word(rd, 32'h0000_0003, "tally");
	endtask : t_burst

	function automatic logic dx(input int i, input logic [3:0] j);
		logic s;
		s = (i < 3) ? j[3] : j[2];
		case (i % 3)
			0: dx = s & j[1];
			1: dx = s & j[0];
			default: dx = s & ~j[1];
		endcase
	endfunction : dx

	task t_data;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, BQ_OFS_EVENT_SEL, {BQ_EVT_BUS_DATA, 16'h0001 << i, 9'h000});
			for (int j = 0; j < 16; j++) begin
				@(posedge pclk);
				dw <= j[3:0];
				@(posedge pclk);
				dw <= 4'h0;
				@(negedge pclk);
				chk_bit(count_inc, dx(i, j[3:0]), "data pulse");
				chk_bit(data_inc, dx(i, j[3:0]), "data activity pulse");
			end
		end
	endtask : t_data

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_alloc();
		t_burst();
		t_data();
		close_out();
	end
endmodule : testbench
`default_nettype wire
